// >>> rtl/cbe_pkg.sv
// constants, state codes and field layout for the channel-access backoff engine
// Behaviour
// - with channel access enabled, assess the channel before each transmission
// - busy or idle comes from the receiver's threshold-compared carrier sense
// - sample carrier sense once per sense interval across the listen span
// - each busy assessment below the limit increments retry count on entering backoff
// - at the retry limit abandon transmission and raise the backoff-limit event
// - during backoff wait stay asleep with the receiver off
// - persistent mode skips backoff and keeps sensing until idle or abort
// - backoff delay is a random count of backoff units from zero to window
// - contention window doubles with every backoff retry
// - optional seed reload at procedure start; else generator keeps its own state
// - channel-access enable is protocol config bit 11, sampled per transmission
// - persistent-sense enable is protocol config bit 9
// - six-bit backoff unit scale sets the length of one backoff unit
// - sense interval code 0..3 selects 64, 128, 256, 512 bit periods
// - listen span is a 1..15 count of sense intervals
// - three-bit field gives the maximum number of backoff retries
// - backoff timer counts ticks of the 34.7 kHz low-power clock
// - abort command 0x67 leaves transmit or receive and returns to ready
package cbe_pkg;
    localparam int unsigned CBE_CFG_W         = 16;
    localparam int unsigned CBE_ACCESS_EN_BIT = 11;
    localparam int unsigned CBE_PERSIST_BIT   = 9;
    localparam int unsigned CBE_SEED_W        = 16;
    localparam int unsigned CBE_BYTE_W        = 8;
    localparam int unsigned CBE_SCALE_W       = 6;
    localparam int unsigned CBE_PERIOD_W      = 2;
    localparam int unsigned CBE_LISTEN_W      = 4;
    localparam int unsigned CBE_RETRY_W       = 3;
    localparam int unsigned CBE_BITCNT_W      = 10;
    localparam int unsigned CBE_DELAY_W       = 8;
    localparam int unsigned CBE_CMD_W         = 8;

    localparam logic [CBE_CMD_W-1:0]    CBE_CMD_ABORT     = 8'h67;
    localparam logic [CBE_BITCNT_W-1:0] CBE_BASE_INTERVAL = 10'h040;
    localparam logic [CBE_BITCNT_W-1:0] CBE_BITCNT_ONE    = 10'h001;
    localparam logic [CBE_SEED_W-1:0]   CBE_LFSR_RESET    = 16'hACE1;
    localparam int unsigned CBE_TAP_A = 15;
    localparam int unsigned CBE_TAP_B = 13;
    localparam int unsigned CBE_TAP_C = 12;
    localparam int unsigned CBE_TAP_D = 10;

    typedef enum logic [3:0] {
        CBE_ST_IDLE    = 4'b0001,
        CBE_ST_SENSE   = 4'b0010,
        CBE_ST_BACKOFF = 4'b0100,
        CBE_ST_TX      = 4'b1000
    } cbe_state_t;
endpackage

// >>> rtl/cbe_engine.sv
// channel-access engine: clear channel assessment and random backoff before transmit
`timescale 1ns/10ps
module cbe_engine #(
    parameter int unsigned RETRY_W  = cbe_pkg::CBE_RETRY_W,
    parameter int unsigned SCALE_W  = cbe_pkg::CBE_SCALE_W,
    parameter int unsigned LISTEN_W = cbe_pkg::CBE_LISTEN_W
) (
    input  wire logic                              clk_in,
    input  wire logic                              rst_b_in,
    input  wire logic [cbe_pkg::CBE_CFG_W-1:0]     protocol_config_in,
    input  wire logic                              seed_reload_enable_in,
    input  wire logic [cbe_pkg::CBE_BYTE_W-1:0]    backoff_seed_high_in,
    input  wire logic [cbe_pkg::CBE_BYTE_W-1:0]    backoff_seed_low_in,
    input  wire logic [SCALE_W-1:0]                backoff_unit_scale_in,
    input  wire logic [cbe_pkg::CBE_PERIOD_W-1:0]  sense_interval_code_in,
    input  wire logic [LISTEN_W-1:0]               listen_span_count_in,
    input  wire logic [RETRY_W-1:0]                retry_limit_value_in,
    input  wire logic                              tx_request_in,
    input  wire logic                              tx_done_in,
    input  wire logic                              command_valid_in,
    input  wire logic [cbe_pkg::CBE_CMD_W-1:0]     command_code_in,
    input  wire logic                              bit_tick_in,
    input  wire logic                              carrier_sense_in,
    input  wire logic                              rc_clock_in,
    output logic                                   rx_enable_out,
    output logic                                   sleep_out,
    output logic                                   tx_active_out,
    output logic                                   tx_start_out,
    output logic                                   backoff_limit_event_out,
    output logic [RETRY_W-1:0]                     retry_count_out
);
    import cbe_pkg::*;

    // the delay counter and window mask are sized for the default retry width
    if (RETRY_W != CBE_RETRY_W || SCALE_W != CBE_SCALE_W || LISTEN_W != CBE_LISTEN_W) begin : g_chk
        $error("cbe_engine: unsupported field width");
    end

    function automatic logic [CBE_DELAY_W-1:0] window_mask(input logic [RETRY_W-1:0] n);
        logic [CBE_DELAY_W:0] one;
        one = {{CBE_DELAY_W{1'b0}}, 1'b1};
        window_mask = CBE_DELAY_W'((one << n) - one);
    endfunction

    // reset release through two flops
    logic rst_meta_q;
    logic rst_sync_q;
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end
    wire rst_n = rst_sync_q;

    // low-power clock arrives as a pin; only its synchronised edge is used
    logic rc_meta_q;
    logic rc_sync_q;
    logic rc_prev_q;
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            rc_meta_q <= 1'b0;
            rc_sync_q <= 1'b0;
            rc_prev_q <= 1'b0;
        end else begin
            rc_meta_q <= rc_clock_in;
            rc_sync_q <= rc_meta_q;
            rc_prev_q <= rc_sync_q;
        end
    end
    wire rc_tick = rc_sync_q & ~rc_prev_q;

    // state and datapath registers
    cbe_state_t               state_q,     state_d;
    logic [CBE_BITCNT_W-1:0]  bit_cnt_q,   bit_cnt_d;
    logic [LISTEN_W-1:0]      listen_q,    listen_d;
    logic                     busy_seen_q, busy_seen_d;
    logic [RETRY_W-1:0]       retry_q,     retry_d;
    logic [CBE_DELAY_W-1:0]   delay_q,     delay_d;
    logic [SCALE_W-1:0]       unit_cnt_q,  unit_cnt_d;
    logic [CBE_SEED_W-1:0]    lfsr_q,      lfsr_d;
    logic                     persist_q,   persist_d;
    logic                     start_q,     start_d;
    logic                     limit_q,     limit_d;

    // decoding
    wire cmd_abort  = command_valid_in && (command_code_in == CBE_CMD_ABORT);
    wire access_en  = protocol_config_in[CBE_ACCESS_EN_BIT];
    wire persist_en = protocol_config_in[CBE_PERSIST_BIT];
    wire [CBE_SEED_W-1:0] seed_word = {backoff_seed_high_in, backoff_seed_low_in};
    wire [CBE_BITCNT_W-1:0] interval_last =
        (CBE_BASE_INTERVAL << sense_interval_code_in) - CBE_BITCNT_ONE;
    wire [LISTEN_W-1:0] listen_last = (listen_span_count_in == '0) ? '0 :
        listen_span_count_in - LISTEN_W'(1);
    wire [SCALE_W-1:0] unit_last = (backoff_unit_scale_in == '0) ? '0 :
        backoff_unit_scale_in - SCALE_W'(1);
    wire lfsr_fb = lfsr_q[CBE_TAP_A] ^ lfsr_q[CBE_TAP_B] ^
                   lfsr_q[CBE_TAP_C] ^ lfsr_q[CBE_TAP_D];
    wire [CBE_SEED_W-1:0] lfsr_step = {lfsr_q[CBE_SEED_W-2:0], lfsr_fb};
    wire in_sense   = (state_q == CBE_ST_SENSE);
    wire sample_now = in_sense && bit_tick_in && (bit_cnt_q == interval_last);
    wire span_done  = sample_now && (listen_q == listen_last);
    wire chan_busy  = busy_seen_q | carrier_sense_in;
    wire at_limit   = (retry_q == retry_limit_value_in);
    wire [RETRY_W-1:0] retry_next = retry_q + RETRY_W'(1);
    wire unit_end   = rc_tick && (unit_cnt_q == unit_last);

    always_comb begin
        state_d     = state_q;
        bit_cnt_d   = bit_cnt_q;
        listen_d    = listen_q;
        busy_seen_d = busy_seen_q;
        retry_d     = retry_q;
        delay_d     = delay_q;
        unit_cnt_d  = unit_cnt_q;
        lfsr_d      = lfsr_q;
        persist_d   = persist_q;
        start_d     = 1'b0;
        limit_d     = 1'b0;
        case (state_q)
            CBE_ST_IDLE: begin
                if (tx_request_in) begin
                    if (access_en) begin
                        state_d     = CBE_ST_SENSE;
                        persist_d   = persist_en;
                        retry_d     = '0;
                        bit_cnt_d   = '0;
                        listen_d    = '0;
                        busy_seen_d = 1'b0;
                        // a zero seed would lock the generator; host must avoid it
                        if (seed_reload_enable_in) begin
                            lfsr_d = seed_word;
                        end
                    end else begin
                        state_d = CBE_ST_TX;
                        start_d = 1'b1;
                    end
                end
            end
            CBE_ST_SENSE: begin
                if (cmd_abort) begin
                    state_d = CBE_ST_IDLE;
                end else if (bit_tick_in) begin
                    bit_cnt_d = sample_now ? '0 : bit_cnt_q + CBE_BITCNT_ONE;
                    if (sample_now) begin
                        busy_seen_d = chan_busy;
                        listen_d    = listen_q + LISTEN_W'(1);
                    end
                    if (span_done) begin
                        listen_d    = '0;
                        busy_seen_d = 1'b0;
                        if (!chan_busy) begin
                            state_d = CBE_ST_TX;
                            start_d = 1'b1;
                        end else if (persist_q) begin
                            state_d = CBE_ST_SENSE;
                        end else if (at_limit) begin
                            state_d = CBE_ST_IDLE;
                            limit_d = 1'b1;
                        end else begin
                            state_d    = CBE_ST_BACKOFF;
                            retry_d    = retry_next;
                            delay_d    = lfsr_q[CBE_DELAY_W-1:0] &
                                         window_mask(retry_next);
                            lfsr_d     = lfsr_step;
                            unit_cnt_d = '0;
                        end
                    end
                end
            end
            CBE_ST_BACKOFF: begin
                if (cmd_abort) begin
                    state_d = CBE_ST_IDLE;
                end else if (delay_q == '0) begin
                    state_d   = CBE_ST_SENSE;
                    bit_cnt_d = '0;
                    listen_d  = '0;
                end else if (rc_tick) begin
                    unit_cnt_d = unit_end ? '0 : unit_cnt_q + SCALE_W'(1);
                    if (unit_end) begin
                        delay_d = delay_q - CBE_DELAY_W'(1);
                    end
                end
            end
            CBE_ST_TX: begin
                if (cmd_abort || tx_done_in) begin
                    state_d = CBE_ST_IDLE;
                end
            end
            default: begin
                state_d = CBE_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            state_q     <= CBE_ST_IDLE;
            bit_cnt_q   <= '0;
            listen_q    <= '0;
            busy_seen_q <= 1'b0;
            retry_q     <= '0;
            delay_q     <= '0;
            unit_cnt_q  <= '0;
            lfsr_q      <= CBE_LFSR_RESET;
            persist_q   <= 1'b0;
            start_q     <= 1'b0;
            limit_q     <= 1'b0;
        end else begin
            state_q     <= state_d;
            bit_cnt_q   <= bit_cnt_d;
            listen_q    <= listen_d;
            busy_seen_q <= busy_seen_d;
            retry_q     <= retry_d;
            delay_q     <= delay_d;
            unit_cnt_q  <= unit_cnt_d;
            lfsr_q      <= lfsr_d;
            persist_q   <= persist_d;
            start_q     <= start_d;
            limit_q     <= limit_d;
        end
    end

    // outputs come straight from the state, pulse and retry count flops
    assign rx_enable_out           = state_q[1];
    assign sleep_out               = state_q[2];
    assign tx_active_out           = state_q[3];
    assign tx_start_out            = start_q;
    assign backoff_limit_event_out = limit_q;
    assign retry_count_out         = retry_q;
endmodule

// >>> verif/cbe_engine_props.sv
// concurrent checks on the channel-access engine ports
`timescale 1ns/10ps
module cbe_engine_props
    import cbe_pkg::*;
#(
    parameter int unsigned RETRY_W = 3
) (
    input wire logic                 clk_in,
    input wire logic                 rst_b_in,
    input wire logic [CBE_CFG_W-1:0] protocol_config_in,
    input wire logic [RETRY_W-1:0]   retry_limit_value_in,
    input wire logic                 tx_request_in,
    input wire logic                 tx_done_in,
    input wire logic                 command_valid_in,
    input wire logic [CBE_CMD_W-1:0] command_code_in,
    input wire logic                 rx_enable_out,
    input wire logic                 sleep_out,
    input wire logic                 tx_active_out,
    input wire logic                 tx_start_out,
    input wire logic                 backoff_limit_event_out,
    input wire logic [RETRY_W-1:0]   retry_count_out
);
    default clocking @(posedge clk_in);
    endclocking
    default disable iff (!rst_b_in);
    wire idle  = !(rx_enable_out || sleep_out || tx_active_out);
    wire abort = command_valid_in && (command_code_in == CBE_CMD_ABORT);
    wire en    = protocol_config_in[CBE_ACCESS_EN_BIT];
    wire pers  = protocol_config_in[CBE_PERSIST_BIT];

    sleep_rx_excl_a: assert property (!(sleep_out && rx_enable_out))
        else $error("receiver on during backoff");
    sense_first_a: assert property (
        idle && tx_request_in && en |=> rx_enable_out && !tx_active_out)
        else $error("enabled request did not start sensing");
    direct_tx_a: assert property (
        idle && tx_request_in && !en |=> tx_start_out && !rx_enable_out)
        else $error("disabled request did not transmit at once");
    start_pulse_a: assert property (tx_start_out |-> tx_active_out ##1 !tx_start_out)
        else $error("transmit start pulse malformed");
    retry_step_a: assert property (
        $rose(sleep_out) |-> retry_count_out == $past(retry_count_out) + RETRY_W'(1))
        else $error("retry count not stepped by one on backoff");
    retry_cap_a: assert property (
        rx_enable_out || sleep_out |-> retry_count_out <= retry_limit_value_in)
        else $error("retry count above limit");
    limit_event_a: assert property (
        backoff_limit_event_out |-> idle ##1 !backoff_limit_event_out)
        else $error("limit event not a single pulse from idle");
    persist_nosleep_a: assert property (
        rx_enable_out && pers && !abort |=> !sleep_out)
        else $error("persistent sensing entered backoff");
    abort_ready_a: assert property (abort && !idle |=> idle && !tx_start_out)
        else $error("abort did not return to idle");
    tx_end_a: assert property (tx_active_out && tx_done_in && !abort |=> !tx_active_out)
        else $error("transmit did not end on done");
endmodule

bind cbe_engine cbe_engine_props #(.RETRY_W(RETRY_W)) cbe_engine_props_inst (
    .clk_in, .rst_b_in, .protocol_config_in, .retry_limit_value_in, .tx_request_in,
    .tx_done_in, .command_valid_in, .command_code_in, .rx_enable_out, .sleep_out,
    .tx_active_out, .tx_start_out, .backoff_limit_event_out, .retry_count_out);

// >>> verif/cbe_radio_model.sv
// receiver and low-power oscillator model feeding the engine's sensing inputs
`timescale 1ns/10ps
module cbe_radio_model #(
    parameter int unsigned RC_HALF = 1441
) (
    input  wire logic clk_in,
    input  wire logic busy_in,
    input  wire logic rx_on_in,
    output logic      bit_tick_out,
    output logic      carrier_sense_out,
    output logic      rc_clock_out
);
    int rc_cnt = 0;
    initial begin
        bit_tick_out = 1'b0;
        carrier_sense_out = 1'b0;
        rc_clock_out = 1'b0;
    end
    // one bit period per clock cycle keeps spans short
    always @(posedge clk_in) bit_tick_out <= #1 1'b1;
    // receiver off: sense output is meaningless, so it wanders
    always @(posedge clk_in) carrier_sense_out <= #1 rx_on_in ? busy_in : ~carrier_sense_out;
    // free-running oscillator, offset in phase from the system clock
    always @(posedge clk_in) begin
        rc_cnt <= (rc_cnt == RC_HALF - 1) ? 0 : rc_cnt + 1;
        if (rc_cnt == RC_HALF - 1) rc_clock_out <= #3 ~rc_clock_out;
    end
endmodule

// >>> verif/tb_csma_ca_backoff_engine.sv
// self-checking bench for the channel-access engine
`timescale 1ns/10ps
module tb_csma_ca_backoff_engine;
    import cbe_pkg::*;
    logic clk_in = 1'b0;
    logic rst_b = 1'b0, reload = 1'b1, req = 1'b0, done = 1'b0, cv = 1'b0, busy = 1'b0;
    logic [15:0] cfg = 16'h0000;
    logic [7:0] cc = 8'h00;
    logic [5:0] scale = 6'h02;
    logic [1:0] code = 2'h0;
    logic [3:0] span = 4'h1;
    logic [2:0] lim = 3'h0, retry;
    logic rx, slp, txa, txs, ev, tick, cs, rc;
    int n_mismatch = 0, samples_checked = 0;
    always #5 clk_in = ~clk_in;

    cbe_engine cbe_engine_inst (.clk_in(clk_in), .rst_b_in(rst_b), .protocol_config_in(cfg),
        .seed_reload_enable_in(reload), .backoff_seed_high_in(8'h5A),
        .backoff_seed_low_in(8'h3C), .backoff_unit_scale_in(scale),
        .sense_interval_code_in(code), .listen_span_count_in(span),
        .retry_limit_value_in(lim), .tx_request_in(req), .tx_done_in(done),
        .command_valid_in(cv), .command_code_in(cc), .bit_tick_in(tick),
        .carrier_sense_in(cs), .rc_clock_in(rc), .rx_enable_out(rx), .sleep_out(slp),
        .tx_active_out(txa), .tx_start_out(txs), .backoff_limit_event_out(ev),
        .retry_count_out(retry));
    cbe_radio_model cbe_radio_model_inst (.clk_in(clk_in), .busy_in(busy), .rx_on_in(rx),
        .bit_tick_out(tick), .carrier_sense_out(cs), .rc_clock_out(rc));

    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic [9:0] seen, input logic [9:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic step();
        @(posedge clk_in);
        #1;
    endtask
    task automatic request();
        step();
        req = 1'b1;
        step();
        req = 1'b0;
    endtask
    task automatic abort();
        cv = 1'b1;
        cc = CBE_CMD_ABORT;
        step();
        cv = 1'b0;
    endtask
    // counts edges from the taking edge; running out ends the run
    task automatic wait_for(input logic on_event, input int bound, output int cyc);
        cyc = 1;
        while ((on_event ? ev : txs) !== 1'b1) begin
            step();
            cyc++;
            if (cyc > bound) begin
                n_mismatch++;
                $display("[FAIL] %0t wait ran out", $time);
                results();
            end
        end
    endtask
    task automatic t_direct();
        int cyc;
        cfg = 16'h0000;
        request();
        wait_for(1'b0, 1, cyc);
        check(10'(rx), 10'h000);
        abort();
        check(10'(txa), 10'h000);
        $display("test direct done");
    endtask
    task automatic t_span(input logic [1:0] c, input logic [3:0] s);
        int cyc;
        code = c;
        span = s;
        busy = 1'b0;
        cfg = 16'h0800; // access bit only, set while idle, no ack or retransmit
        request();
        check(10'(rx), 10'h001);
        wait_for(1'b0, 8000, cyc);
        check(10'(cyc), 10'((64 << c) * s + 1));
        done = 1'b1;
        step();
        done = 1'b0;
        check(10'(txa), 10'h000);
        $display("test span %0d x %0d done", c, s);
    endtask
    task automatic t_limit(input logic [2:0] l);
        int cyc, slept;
        lim = l;
        busy = 1'b1;
        cfg = 16'h0800;
        code = 2'h0;
        span = 4'h1;
        slept = 0;
        request();
        cyc = 1;
        while (ev !== 1'b1) begin
            step();
            cyc++;
            if (slp === 1'b1) slept++;
            if (cyc > 40000) begin
                n_mismatch++;
                $display("[FAIL] %0t limit wait ran out", $time);
                results();
            end
        end
        check(10'(ev), 10'h001);
        check(10'(retry), 10'(l));
        check(10'(slept != 0), 10'(l != 0));
        // seed 16'h5A3C: first window draws zero, second draws one unit of two rc ticks
        if (l == 3'h2) begin
            check(10'(slept >= 2885 && slept <= 5766), 10'h001);
        end
        check(10'(txa), 10'h000);
        $display("test limit %0d done", l);
    endtask
    task automatic t_persist();
        cfg = 16'h0A00;
        busy = 1'b1;
        reload = 1'b0; // generator runs on from its own state
        request();
        repeat (300) step();
        check(10'(rx), 10'h001);
        check(10'(retry), 10'h000);
        abort();
        check(10'(rx), 10'h000);
        busy = 1'b0;
        $display("test persist done");
    endtask

    initial begin
        repeat (5) @(posedge clk_in);
        #1 rst_b = 1'b1;
        repeat (3) step();
        t_direct();
        for (int i = 0; i < 4; i++) t_span(2'(i), 4'h1);
        t_span(2'h0, 4'hF);
        t_limit(3'h0);
        t_limit(3'h2);
        t_persist();
        results();
    end
endmodule
